// file: src/id_leaves_regs.svh
// Purpose: Named constants for the cache/TLB and power identification leaves
// Assumes: Included by bare name from every design file that needs it
// Notes:   Definitions only; ranges are used as part-selects
`ifndef ID_LEAVES_REGS_SVH
`define ID_LEAVES_REGS_SVH

// Function numbers answered by this block
`define LEAF_CACHE_TLB          32'h80000006
`define LEAF_POWER              32'h80000007

// Associativity codes (4-bit fields)
`define ASSOC_OFF               4'h0
`define ASSOC_DIRECT            4'h1
`define ASSOC_2WAY              4'h2
`define ASSOC_4WAY              4'h4
`define ASSOC_8WAY              4'h6
`define ASSOC_16WAY             4'h8
`define ASSOC_32WAY             4'hA
`define ASSOC_48WAY             4'hB
`define ASSOC_64WAY             4'hC
`define ASSOC_FULL              4'hF

// Field ranges shared by the TLB words
`define FLD_DATA_WAYS           31:28
`define FLD_DATA_ENTRIES        27:16
`define FLD_INSTR_WAYS          15:12
`define FLD_INSTR_ENTRIES       11:0
`define FLD_UPPER_HALF          31:16

// Field ranges shared by the cache words
`define FLD_CACHE_KB            31:16
`define FLD_CACHE_WAYS          15:12
`define FLD_CACHE_LPT           11:8
`define FLD_CACHE_LINE          7:0

// Fixed field values
`define TLB_LARGE_WAYS          4'h0
`define TLB_LARGE_ENTRIES       12'h000
`define TLB_SMALL_ENTRIES       12'h200
`define L2_WAYS_PRINTED         4'h8
`define L2_LINES_PER_TAG        4'h1
`define L2_LINE_BYTES           8'h40
`define L3_KB                   16'h0000
`define L3_WAYS                 4'h0
`define L3_LINES_PER_TAG        4'h0
`define L3_LINE_BYTES           8'h00
`define L2_KB_256               16'h0100
`define L2_KB_512               16'h0200
`define L2_KB_1024              16'h0400

// Power flag bit positions
`define PWR_TSC_CONST_BIT       8
`define PWR_HW_PSTATE_BIT       7
`define PWR_FINE_STEP_BIT       6
`define PWR_THERMAL_CTL_BIT     4
`define PWR_THERM_TRIP_BIT      3
`define PWR_VOLT_CODE_BIT       2
`define PWR_FREQ_CODE_BIT       1
`define PWR_TEMP_SENSOR_BIT     0

// Table addressing and word values
`define WORD_ZERO               32'h00000000
`define WORD_IDX_FIRST          2'h0
`define WORD_IDX_LAST           2'h3
`define STRAP_SEL_512           2'h1
`define STRAP_SEL_1024          2'h2

`endif

// file: src/id_leaves_pkg.sv
// Purpose: Shared types of the identification leaves block
// Assumes: Constants live in id_leaves_regs.svh
// Notes:   Types only
package id_leaves_pkg;
    // Table word address: leaf select on top, word index below
    typedef logic [2:0]  rom_addr_t;
    typedef logic [31:0] id_word_t;
    typedef logic [1:0]  word_idx_t;
    typedef logic [15:0] cache_kb_t;
    // Sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_FETCH = 3'b010,
        ST_DRAIN = 3'b100
    } seq_state_t;
endpackage

// file: src/id_rom_if.sv
// Purpose: Carrier between the sequencer and the leaf table
// Assumes: Single clock domain
// Notes:   Read data arrive one cycle after rd_en
`timescale 1ns/1ps
interface id_rom_if;
    import id_leaves_pkg::*;
    logic      rd_en;     // Read strobe
    rom_addr_t addr;      // Leaf and word index
    id_word_t  rd_data;   // Registered table word
    cache_kb_t l2_kb;     // Strap-selected second cache size
    logic      thermal;   // Strap-selected thermal control flag
    modport requester (output rd_en, addr, l2_kb, thermal, input rd_data);
    modport table_side (input rd_en, addr, l2_kb, thermal, output rd_data);
endinterface // id_rom_if

// file: src/leaf_word_rom.sv
// Purpose: Constant table of the eight identification words
// Assumes: Strap fields are stable while read
// Notes:   Read data come from a register
`timescale 1ns/1ps
`include "id_leaves_regs.svh"
module leaf_word_rom (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // Table port
    id_rom_if.table_side rom
);
    import id_leaves_pkg::*;

    // Table contents as a function of address and straps
    function automatic id_word_t table_word(input rom_addr_t a,
                                            input cache_kb_t kb,
                                            input logic th);
        id_word_t w;
        w = `WORD_ZERO;
        case (a)
            3'h0: begin // Large-page TLB word
                w[`FLD_DATA_WAYS]     = `TLB_LARGE_WAYS;
                w[`FLD_DATA_ENTRIES]  = `TLB_LARGE_ENTRIES;
                w[`FLD_INSTR_WAYS]    = `TLB_LARGE_WAYS;
                w[`FLD_INSTR_ENTRIES] = `TLB_LARGE_ENTRIES;
            end
            3'h1: begin // Small-page TLB word
                w[`FLD_DATA_WAYS]     = `ASSOC_4WAY;
                w[`FLD_DATA_ENTRIES]  = `TLB_SMALL_ENTRIES;
                w[`FLD_INSTR_WAYS]    = `ASSOC_4WAY;
                w[`FLD_INSTR_ENTRIES] = `TLB_SMALL_ENTRIES;
            end
            3'h2: begin // Second cache word
                w[`FLD_CACHE_KB]   = kb;
                w[`FLD_CACHE_WAYS] = `L2_WAYS_PRINTED;
                w[`FLD_CACHE_LPT]  = `L2_LINES_PER_TAG;
                w[`FLD_CACHE_LINE] = `L2_LINE_BYTES;
            end
            3'h3: begin // No third cache
                w[`FLD_CACHE_KB]   = `L3_KB;
                w[`FLD_CACHE_WAYS] = `L3_WAYS;
                w[`FLD_CACHE_LPT]  = `L3_LINES_PER_TAG;
                w[`FLD_CACHE_LINE] = `L3_LINE_BYTES;
            end
            3'h7: begin // Power feature flags; rest reserved zero
                w[`PWR_TSC_CONST_BIT]   = 1'b1;
                w[`PWR_HW_PSTATE_BIT]   = 1'b1;
                w[`PWR_FINE_STEP_BIT]   = 1'b1;
                w[`PWR_THERMAL_CTL_BIT] = th;
                w[`PWR_THERM_TRIP_BIT]  = 1'b1;
                w[`PWR_VOLT_CODE_BIT]   = 1'b0;
                w[`PWR_FREQ_CODE_BIT]   = 1'b0;
                w[`PWR_TEMP_SENSOR_BIT] = 1'b1;
            end
            default: w = `WORD_ZERO; // Reserved power words
        endcase
        return w;
    endfunction

    // Combinational lookup
    id_word_t lookup_word;
    assign lookup_word = table_word(rom.addr, rom.l2_kb, rom.thermal);

    // Registered read port
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rom.rd_data <= `WORD_ZERO;
        end else if (rom.rd_en) begin
            rom.rd_data <= lookup_word;
        end
    end
endmodule // leaf_word_rom

// file: src/product_strap_latch.sv
// Purpose: Captures product straps once after reset release
// Assumes: Straps are static while the part runs
// Notes:   Caught by a clocked process, never by the reset itself
`timescale 1ns/1ps
`include "id_leaves_regs.svh"
module product_strap_latch (
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    sys_rst,
    // Strap pins
    input  wire logic [1:0]              strap_l2_size_sel,
    input  wire logic                    strap_thermal_ctl,
    // Latched values
    output id_leaves_pkg::cache_kb_t     l2_kb,
    output logic                         thermal,
    output logic                         captured
);
    import id_leaves_pkg::*;

    // Size decode; unused code falls back to the smallest size
    cache_kb_t decoded_kb;
    assign decoded_kb = (strap_l2_size_sel == `STRAP_SEL_512)  ? `L2_KB_512 :
                        (strap_l2_size_sel == `STRAP_SEL_1024) ? `L2_KB_1024 :
                                                                 `L2_KB_256;

    // One capture on the first cycle out of reset
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            l2_kb    <= `L2_KB_256;
            thermal  <= 1'b0;
            captured <= 1'b0;
        end else if (!captured) begin
            l2_kb    <= decoded_kb;
            thermal  <= strap_thermal_ctl;
            captured <= 1'b1;
        end
    end
endmodule // product_strap_latch

// file: src/cache_tlb_power_id_leaves.sv
// Purpose: Answers the cache/TLB and power identification functions
// Assumes: One query at a time; straps static after reset
// Notes:   Four result words land one per cycle, the last with a one-cycle valid
//
// Functional notes
// - Associativity fields use the fixed 4-bit code set
// - Large-page data TLB ways and entries zero
// - Large-page instruction TLB ways and entries zero
// - Small-page data TLB: four-way, 512 entries
// - Small-page instruction TLB: four-way, 512 entries
// - Second cache size from strap: 256/512/1024
// - Second cache: ways 8, one line/tag, 64B
// - Third cache word reports no third cache
// - Power flag: constant-rate timestamp counter set
// - Power flag: hardware performance-state control set
// - Power flag: fine multiplier steps set
// - Power flag: thermal control from product strap
// - Power flag: catastrophic heat shutdown set
// - Power flags: voltage and frequency codes clear
// - Power flag: temperature sensor present set
`timescale 1ns/1ps
`include "id_leaves_regs.svh"
module cache_tlb_power_id_leaves (
    // Clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    sys_rst,
    // Query request
    input  wire logic                    query_valid,
    input  wire id_leaves_pkg::id_word_t query_leaf,
    // Product straps
    input  wire logic [1:0]              strap_l2_size_sel,
    input  wire logic                    strap_thermal_ctl,
    // Query answer
    output logic                         query_busy,
    output logic                         result_valid,
    output logic                         result_known,
    output id_leaves_pkg::id_word_t      result_a,
    output id_leaves_pkg::id_word_t      result_b,
    output id_leaves_pkg::id_word_t      result_c,
    output id_leaves_pkg::id_word_t      result_d
);
    import id_leaves_pkg::*;

    // Checks that a code belongs to the associativity set
    function automatic logic ways_code_legal(input logic [3:0] c);
        return (c == `ASSOC_OFF)   || (c == `ASSOC_DIRECT) ||
               (c == `ASSOC_2WAY)  || (c == `ASSOC_4WAY)   ||
               (c == `ASSOC_8WAY)  || (c == `ASSOC_16WAY)  ||
               (c == `ASSOC_32WAY) || (c == `ASSOC_48WAY)  ||
               (c == `ASSOC_64WAY) || (c == `ASSOC_FULL);
    endfunction

    // Table carrier and strap values
    id_rom_if   rom_bus ();
    cache_kb_t  strap_kb;        // Latched second cache size
    logic       strap_thermal;   // Latched thermal flag
    logic       strap_ready;     // Straps caught after reset

    // Sequencer state
    seq_state_t state;           // Current state
    seq_state_t next_state;      // Next state
    logic       leaf_is_power;   // Latched leaf select
    word_idx_t  issue_idx;       // Word being read
    word_idx_t  cap_idx;         // Word arriving from the table
    logic       cap_pending;     // Table data valid this cycle

    // Decode of the incoming function number
    logic hit_cache;             // Cache/TLB leaf requested
    logic hit_power;             // Power leaf requested
    logic accept;                // Query taken this cycle
    logic last_issue;            // Fourth word being issued
    assign hit_cache  = (query_leaf == `LEAF_CACHE_TLB);
    assign hit_power  = (query_leaf == `LEAF_POWER);
    assign accept     = (state == ST_IDLE) && query_valid && strap_ready;
    assign last_issue = (state == ST_FETCH) &&
                        (issue_idx == `WORD_IDX_LAST);

    // Encoding check: TLB way fields and the cache way fields must be
    // legal codes; a failing word is forced to zero so a
    // corrupted table never leaks a reserved code to software.
    logic word_ok;
    assign word_ok = leaf_is_power || (cap_idx > 2'h1) ||
                     (ways_code_legal(rom_bus.rd_data[`FLD_DATA_WAYS]) &&
                      ways_code_legal(rom_bus.rd_data[`FLD_INSTR_WAYS]));
    logic cache_ok;
    assign cache_ok = leaf_is_power || (cap_idx < 2'h2) ||
                      ways_code_legal(rom_bus.rd_data[`FLD_CACHE_WAYS]);
    id_word_t cap_word;
    assign cap_word = (word_ok && cache_ok) ? rom_bus.rd_data
                                            : `WORD_ZERO;

    // Table address and read strobe
    assign rom_bus.rd_en   = (state == ST_FETCH);
    assign rom_bus.addr    = {leaf_is_power, issue_idx};
    assign rom_bus.l2_kb   = strap_kb;
    assign rom_bus.thermal = strap_thermal;

    // Leaf table
    leaf_word_rom u_rom (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .rom     (rom_bus.table_side)
    );

    // Strap capture
    product_strap_latch u_straps (
        .clk_sys           (clk_sys),
        .sys_rst           (sys_rst),
        .strap_l2_size_sel (strap_l2_size_sel),
        .strap_thermal_ctl (strap_thermal_ctl),
        .l2_kb             (strap_kb),
        .thermal           (strap_thermal),
        .captured          (strap_ready)
    );

    // Next-state logic
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (accept && (hit_cache || hit_power)) begin
                    next_state = ST_FETCH;
                end else if (accept) begin
                    // Unknown leaf: answer zeros at once
                    next_state = ST_DRAIN;
                end
            end
            ST_FETCH: begin
                if (last_issue) begin
                    next_state = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // State register and busy flag
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state      <= ST_IDLE;
            query_busy <= 1'b0;
        end else begin
            state      <= next_state;
            query_busy <= (next_state != ST_IDLE);
        end
    end

    // Leaf latch and word index; nothing else changes on a read
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            leaf_is_power <= 1'b0;
            issue_idx     <= `WORD_IDX_FIRST;
        end else if (accept) begin
            leaf_is_power <= hit_power;
            issue_idx     <= `WORD_IDX_FIRST;
        end else if (state == ST_FETCH) begin
            issue_idx     <= issue_idx + 2'h1;
        end
    end

    // Tracks which word the table returns next cycle
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cap_idx     <= `WORD_IDX_FIRST;
            cap_pending <= 1'b0;
        end else begin
            cap_idx     <= issue_idx;
            cap_pending <= (state == ST_FETCH);
        end
    end

    // Result words: cleared on accept, filled as table data arrive
    always_ff @(posedge clk_sys) begin
        if (sys_rst || accept) begin
            result_a <= `WORD_ZERO;
            result_b <= `WORD_ZERO;
            result_c <= `WORD_ZERO;
            result_d <= `WORD_ZERO;
        end else if (cap_pending) begin
            case (cap_idx)
                2'h0:    result_a <= cap_word;
                2'h1:    result_b <= cap_word;
                2'h2:    result_c <= cap_word;
                default: result_d <= cap_word;
            endcase
        end
    end

    // One-cycle valid when the last word has landed
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            result_valid <= 1'b0;
            result_known <= 1'b0;
        end else begin
            result_valid <= (state == ST_DRAIN);
            if (accept) begin
                result_known <= hit_cache || hit_power;
            end
        end
    end
endmodule // cache_tlb_power_id_leaves

// file: dv/id_leaves_monitor.sv
// Purpose: Port-level checks of the cache/TLB and power identification block
// Assumes: Straps change only while sys_rst is held
// Notes:   Attached to the top module by the bind after endmodule
`timescale 1ns/1ps
`include "id_leaves_regs.svh"
module id_leaves_monitor
    import id_leaves_pkg::*;
(
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    // Query request
    input wire logic       query_valid,
    input wire id_word_t   query_leaf,
    // Product straps
    input wire logic [1:0] strap_l2_size_sel,
    input wire logic       strap_thermal_ctl,
    // Query answer
    input wire logic       query_busy,
    input wire logic       result_valid,
    input wire logic       result_known,
    input wire id_word_t   result_a,
    input wire id_word_t   result_b,
    input wire id_word_t   result_c,
    input wire id_word_t   result_d
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    id_word_t    prev_leaf;   // Leaf seen at the last edge
    logic        prev_busy;   // Busy seen at the last edge
    id_word_t    taken_leaf;  // Leaf of the query in flight
    logic        busy_rise;   // First busy cycle of a query
    logic        prev_known;  // Accepted leaf is one of the two
    logic        cache_done;  // Cache/TLB answer on the outputs
    logic        power_done;  // Power answer on the outputs
    logic [15:0] exp_kb;      // Size the straps ask for

    assign busy_rise  = query_busy && !prev_busy;
    assign prev_known = (prev_leaf == `LEAF_CACHE_TLB) ||
                        (prev_leaf == `LEAF_POWER);
    assign cache_done = result_valid && (taken_leaf == `LEAF_CACHE_TLB);
    assign power_done = result_valid && (taken_leaf == `LEAF_POWER);
    // Code 3 falls back to the smallest size
    assign exp_kb = (strap_l2_size_sel == 2'h1) ? 16'h0200 :
                    (strap_l2_size_sel == 2'h2) ? 16'h0400 : 16'h0100;

    // Busy rises one edge after accept, so the leaf is one edge old
    always_ff @(posedge clk_sys) begin
        prev_leaf  <= query_leaf;
        prev_busy  <= sys_rst ? 1'b0 : query_busy;
        taken_leaf <= sys_rst ? `WORD_ZERO :
                      (busy_rise ? prev_leaf : taken_leaf);
    end

    // Reserved way codes must never appear
    function automatic logic legal_ways(input logic [3:0] w);
        return w inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hA, 4'hB,
                         4'hC, 4'hF};
    endfunction

    large_page_a: assert property (
        cache_done |-> result_a == 32'h00000000)
        else $error("large page TLB word not zero");
    small_page_a: assert property (
        cache_done |-> result_b == 32'h42004200)
        else $error("small page TLB word wrong");
    cache_words_a: assert property (
        cache_done |-> result_c[15:0] == 16'h8140 && result_d == 32'h0)
        else $error("cache description words wrong");
    cache_size_a: assert property (
        cache_done |-> result_c[31:16] == exp_kb)
        else $error("second cache size does not follow straps");
    way_codes_a: assert property (
        cache_done |-> legal_ways(result_a[31:28]) &&
            legal_ways(result_a[15:12]) && legal_ways(result_b[31:28]) &&
            legal_ways(result_b[15:12]) && legal_ways(result_c[15:12]) &&
            legal_ways(result_d[15:12]))
        else $error("reserved associativity code returned");
    power_set_a: assert property (
        power_done |-> result_d[8:6] == 3'h7 && result_d[3] && result_d[0])
        else $error("power feature flag missing");
    power_clear_a: assert property (
        power_done |-> result_d[2:1] == 2'h0 && result_d[31:9] == 23'h0 &&
            !result_d[5] && (result_a | result_b | result_c) == 32'h0)
        else $error("power reserved or cleared bits set");
    thermal_flag_a: assert property (
        power_done |-> result_d[4] == strap_thermal_ctl)
        else $error("thermal control flag does not follow strap");
    // Busy rises in cycle 1, the answer pulse stands in cycle 6
    known_delay_a: assert property (
        busy_rise && prev_known |->
            !result_valid [*5] ##1 (result_valid && result_known))
        else $error("known leaf answer not on time");
    unknown_zero_a: assert property (
        busy_rise && !prev_known |-> ##1 (result_valid && !result_known &&
            (result_a | result_b | result_c | result_d) == 32'h0))
        else $error("unknown leaf answer wrong");
    // Nothing but a request may start a read sequence
    busy_cause_a: assert property (
        busy_rise |-> $past(query_valid))
        else $error("busy without a query");
endmodule // id_leaves_monitor

bind cache_tlb_power_id_leaves id_leaves_monitor u_monitor (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .query_valid(query_valid),
    .query_leaf(query_leaf), .strap_l2_size_sel(strap_l2_size_sel),
    .strap_thermal_ctl(strap_thermal_ctl), .query_busy(query_busy),
    .result_valid(result_valid), .result_known(result_known),
    .result_a(result_a), .result_b(result_b), .result_c(result_c),
    .result_d(result_d)
);

// file: dv/tb_top.sv
// Purpose: Self-checking bench of the identification leaves block
// Assumes: Inputs change at falling edges only
// Notes:   Straps are changed only under reset, as the block latches once
`timescale 1ns/1ps
`include "id_leaves_regs.svh"
module tb_top;
    import id_leaves_pkg::*;

    logic       clk_sys = 1'b0;            // 125 MHz system clock
    logic       sys_rst = 1'b1;            // Synchronous reset
    logic       query_valid = 1'b0;        // Request strobe
    id_word_t   query_leaf = `WORD_ZERO;   // Function number
    logic [1:0] strap_l2_size_sel = 2'h0;  // Size strap
    logic       strap_thermal_ctl = 1'b0;  // Thermal strap
    logic       query_busy;                // Busy level
    logic       result_valid;              // Answer pulse
    logic       result_known;              // Leaf recognised
    id_word_t   result_a, result_b, result_c, result_d;
    int         err_count = 0;             // Mismatches seen
    int         checks = 0;                // Comparisons made
    int         lat;                       // Edges from accept to answer
    id_word_t   got [4];                   // Words of the last answer

    always #4 clk_sys = ~clk_sys;

    cache_tlb_power_id_leaves dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .query_valid(query_valid),
        .query_leaf(query_leaf), .strap_l2_size_sel(strap_l2_size_sel),
        .strap_thermal_ctl(strap_thermal_ctl), .query_busy(query_busy),
        .result_valid(result_valid), .result_known(result_known),
        .result_a(result_a), .result_b(result_b), .result_c(result_c),
        .result_d(result_d));

    // One comparison, counted; four-state so an unknown never matches
    task automatic cmp(input id_word_t g, input id_word_t e, input string m);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic results();
        if (err_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Reset with new straps; a query in capture cycle must be ignored
    task automatic do_reset(input logic [1:0] sel, input logic th);
        sys_rst = 1'b1;
        strap_l2_size_sel = sel;
        strap_thermal_ctl = th;
        repeat (10) @(negedge clk_sys);
        cmp({29'h0, query_busy, result_valid, result_known}, 0, "rst flags");
        cmp(result_a | result_b | result_c | result_d, 0, "rst words");
        sys_rst = 1'b0;
        query_valid = 1'b1;
        query_leaf = `LEAF_CACHE_TLB;
        @(negedge clk_sys);
        query_valid = 1'b0;
        repeat (2) @(negedge clk_sys);
        cmp({31'h0, query_busy}, 0, "early query taken");
    endtask

    // Entered at a falling edge; returns at the falling edge of the pulse
    task automatic query(input id_word_t leaf, input int exp_lat);
        query_valid = 1'b1;
        query_leaf = leaf;
        @(negedge clk_sys);
        query_valid = 1'b0;
        cmp({31'h0, query_busy}, 1, "busy after accept");
        lat = 1;
        while (result_valid !== 1'b1 && lat < 20) begin
            @(posedge clk_sys);
            #1;
            lat++;
        end
        if (lat >= 20) begin
            err_count++;
            $display("[FAIL] %0t no answer", $time);
            results();
        end
        got = '{result_a, result_b, result_c, result_d};
        cmp({31'h0, query_busy}, 0, "busy at answer");
        cmp(lat, exp_lat, "answer latency");
        @(negedge clk_sys);
    endtask

    // Both leaves under one strap setting, back to back
    task automatic scen_leaves(input logic [1:0] sel, input logic th);
        id_word_t first [4];
        logic [15:0] kb;
        kb = (sel == 2'h1) ? 16'h0200 : (sel == 2'h2) ? 16'h0400 : 16'h0100;
        do_reset(sel, th);
        query(`LEAF_CACHE_TLB, 6);
        cmp({31'h0, result_known}, 1, "known flag");
        cmp(got[0], 32'h0, "large page word");
        cmp(got[1], {4'h4, 12'd512, 4'h4, 12'd512},
            "small page");
        cmp(got[2], {kb, 4'h8, 4'h1, 8'd64},
            "second cache");
        cmp(got[3], 32'h0, "third cache");
        first = got;
        query(`LEAF_CACHE_TLB, 6);
        for (int i = 0; i < 4; i++)
            cmp(got[i], first[i], "repeat read");
        query(`LEAF_POWER, 6);
        cmp({31'h0, result_known}, 1, "power known flag");
        cmp(got[0] | got[1] | got[2], 32'h0, "power reserved words");
        cmp(got[3], 32'h1C9 | ({31'h0, th} << 4), "power flags");
    endtask

    // Unrecognised leaves answer zeros early
    task automatic scen_unknown();
        query(32'h80000005, 2);
        cmp({31'h0, result_known}, 0, "unknown known flag");
        cmp(got[0] | got[1] | got[2] | got[3], 0, "unknown words");
        query(32'h80000008, 2);
    endtask

    // A request while busy is dropped without a second answer
    task automatic scen_refused();
        query_valid = 1'b1;
        query_leaf = `LEAF_CACHE_TLB;
        @(negedge clk_sys);
        query_leaf = `LEAF_POWER;
        repeat (2) @(negedge clk_sys);
        query_valid = 1'b0;
        // Taken in cycle 0, this is cycle 3; the pulse stands in cycle 6
        repeat (3) @(negedge clk_sys);
        cmp({31'h0, result_valid}, 1, "answer pulse");
        cmp(result_b, 32'h42004200, "answer of first leaf");
        lat = 0;
        repeat (10) begin
            @(negedge clk_sys);
            lat = lat + int'(result_valid === 1'b1);
        end
        cmp(lat, 0, "refused request answered");
    endtask

    initial begin
        for (int i = 0; i < 4; i++)
            scen_leaves(i[1:0], i[0]);
        scen_unknown();
        scen_refused();
        results();
    end
endmodule // tb_top
